/* File: verilog/ccut_timer_regs.svh */
// register offsets, field positions, reset values and timing counts of the ccu time bases
`ifndef CCUT_TIMER_REGS_SVH
`define CCUT_TIMER_REGS_SVH

`define CCUT_ADDR_GP_CTRL      8'hc8
`define CCUT_ADDR_IRQ_REQ      8'hc0
`define CCUT_ADDR_IRQ_EN1      8'hb8
`define CCUT_ADDR_RC_LOW       8'hca
`define CCUT_ADDR_RC_HIGH      8'hcb
`define CCUT_ADDR_GP_CNT_LOW   8'hcc
`define CCUT_ADDR_GP_CNT_HIGH  8'hcd
`define CCUT_ADDR_FT_RELOAD_LO 8'hde
`define CCUT_ADDR_FT_RELOAD_HI 8'hdf
`define CCUT_ADDR_FT_CTRL      8'he1
`define CCUT_ADDR_FT_CNT_LOW   8'he2
`define CCUT_ADDR_FT_CNT_HIGH  8'he3

// gp timer control fields
`define CCUT_GC_INSEL_LO   0
`define CCUT_GC_INSEL_HI   1
`define CCUT_GC_CMPMODE    2
`define CCUT_GC_RLD_LO     3
`define CCUT_GC_RLD_HI     4
`define CCUT_GC_PRESCALE   7
// irq request and enable fields
`define CCUT_IR_EXT_RELOAD 7
`define CCUT_IR_OVERFLOW   6
`define CCUT_IE_EXT_RLD_EN 7
`define CCUT_IE_GP_IRQ_EN  1
`define CCUT_IE_FT_IRQ_EN  0
// fast timer control fields
`define CCUT_FC_OVERFLOW   3
`define CCUT_FC_GP_PS_EXT  7

`define CCUT_GP_CTRL_RESET 8'h00
`define CCUT_FT_CTRL_RESET 8'h00
`define CCUT_IRQ_RESET     8'h00

// machine cycle = 12 oscillator periods; one clk_sys period = one oscillator period
`define CCUT_MACHINE_CYCLE 4'd12

`endif

/* File: verilog/ccut_pkg.sv */
// types shared by the ccu time base modules
package ccut_pkg;

  typedef enum logic [1:0] {
    CCUT_IN_STOP  = 2'b00,
    CCUT_IN_TIMER = 2'b01,
    CCUT_IN_COUNT = 2'b10,
    CCUT_IN_GATED = 2'b11
  } ccut_insel_t;

  typedef enum logic [1:0] {
    CCUT_FT_IDLE = 2'b00,
    CCUT_FT_LOAD = 2'b01,
    CCUT_FT_RUN  = 2'b11
  } ccut_ft_state_t;

endpackage : ccut_pkg

/* File: verilog/ccut_edge_sampler.sv */
// two-flop synchroniser plus once-per-machine-cycle sampler with falling-edge detect
`timescale 1ns/100ps
module ccut_edge_sampler (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // pin and sample strobe
  input  wire logic pinIn,
  input  wire logic sampleEn,
  // results
  output logic      level,
  output logic      fallSeen
);

  logic syncA_q;
  logic syncB_q;
  logic prev_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end

  // one sample per machine cycle, so high then low on consecutive samples is an edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level    <= 1'b0;
      prev_q   <= 1'b0;
      fallSeen <= 1'b0;
    end else begin
      fallSeen <= 1'b0;
      if (sampleEn) begin
        prev_q   <= syncB_q;
        level    <= syncB_q;
        fallSeen <= prev_q & ~syncB_q;
      end
    end
  end

endmodule : ccut_edge_sampler

/* File: verilog/ccut_fast_prescaler.sv */
// binary prescaler for the fast compare timer: oscillator divided by 2 up to 256
`timescale 1ns/100ps
module ccut_fast_prescaler (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // control
  input  wire logic       restart,
  input  wire logic [2:0] divSel,
  // tick
  output logic            tick
);

  logic [7:0] div_q;
  logic [7:0] mask;

  // 000 -> /2 uses bit 0 only, 111 -> /256 uses all eight bits
  assign mask = 8'hff >> (3'h7 - divSel);

  always_ff @(posedge clk_sys) begin
    if (srst || restart) begin
      div_q <= 8'h00;
      tick  <= 1'b0;
    end else begin
      div_q <= div_q + 8'h01;
      tick  <= ((div_q & mask) == mask);
    end
  end

endmodule : ccut_fast_prescaler

/* File: verilog/ccut_timer_top.sv */
// general timer and fast compare timer of the compare/capture unit with register port
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "ccut_timer_regs.svh"

// How it works
// RULE1 - timer mode counts each machine cycle, or every second one when prescaled
// RULE2 - gated mode counts only while the sampled gate pin is high
// RULE3 - counter mode increments one cycle after a sampled high-to-low on the pin
// RULE4 - external count source holds each level at least one machine cycle
// RULE5 - software keeps both prescale bits zero in counter mode
// RULE6 - rollover from all ones sets the overflow flag at bit 6 of irq request
// RULE7 - software clears overflow flag and checks which flag raised the shared vector
// RULE8 - input select: 00 stop, 01 timer, 10 counter, 11 gated timer
// RULE9 - reload select: upper bit 0 off, 10 on overflow, 11 on trigger falling edge
// RULE10 - overflow reload loads the reload/compare value in the flag-setting cycle
// RULE11 - trigger edge reloads count and sets ext-reload flag when enabled
// RULE12 - ext-reload flag set raises the timer interrupt when enabled
// RULE13 - trigger pin sampled per machine cycle, reload the cycle after the edge
// RULE14 - compare mode bit selects compare mode 1 when set, mode 0 when clear
// RULE15 - fast compare outputs run mode 0: overflow drives low, match drives high
// RULE16 - fast timer clock is oscillator over 2 to 256, binary coded field
// RULE17 - fast control register writable any time, resets to 00 hex
// RULE18 - fast timer runs free and reloads from its reload register on overflow
// RULE19 - first write to low reload byte starts the fast timer
// RULE20 - low reload byte write while running reloads the count next cycle
// RULE21 - software writes high reload byte before low byte
// RULE22 - fast overflow flag raises an interrupt when its enable is set
// RULE23 - fast overflow flag sets on rollover from all ones to the reload value
// RULE24 - input select 00 holds the count apart from writes and trigger reloads
module ccut_timer_top
  import ccut_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // pins
  input  wire logic        gpTimerExtCountGatePin,
  input  wire logic        reloadTriggerPin,
  // fast compare match and output level
  input  wire logic        fastCompareMatch,
  output logic             fastCompareOut,
  // status to the rest of the unit
  output logic             gpTimerIrq,
  output logic             fastTimerIrq,
  output logic             compareModeOne,
  output logic [15:0]      gpTimerCount,
  output logic [15:0]      fastTimerCount
);

  // registers
  logic [7:0]     gpCtrl_q;
  logic [7:0]     irqEn_q;
  logic           ovfFlag_q;
  logic           extFlag_q;
  logic [15:0]    reloadCompare_q;
  logic [15:0]    gpCnt_q;
  logic [7:0]     ftCtrl_q;
  logic           ftOvf_q;
  logic [15:0]    ftReload_q;
  logic [15:0]    ftCnt_q;
  ccut_ft_state_t ftState_q;
  logic [3:0]     mcDiv_q;
  logic           prescPhase_q;

  // decoded controls
  ccut_insel_t inSel;
  logic        gpPrescale;
  logic        rldOn;
  logic        rldExt;
  logic        mcTick;
  logic        gateLevel;
  logic        countFall;
  logic        trigFall;
  logic        gpInc;
  logic        gpRoll;
  logic        ftTick;
  logic        ftRoll;
  logic        wrLowReload;
  logic        extReload;

  assign inSel       = ccut_insel_t'({gpCtrl_q[`CCUT_GC_INSEL_HI], gpCtrl_q[`CCUT_GC_INSEL_LO]}); // RULE8
  // either prescale select doubles the timer period
  assign gpPrescale  = gpCtrl_q[`CCUT_GC_PRESCALE] | ftCtrl_q[`CCUT_FC_GP_PS_EXT];
  assign rldOn       = gpCtrl_q[`CCUT_GC_RLD_HI]; // RULE9
  assign rldExt      = gpCtrl_q[`CCUT_GC_RLD_LO]; // RULE9
  // pins are sampled on this strobe too, so gate, count and trigger share one phase
  assign mcTick      = (mcDiv_q == `CCUT_MACHINE_CYCLE - 4'd1);
  assign wrLowReload = regWr && (regAddr == `CCUT_ADDR_FT_RELOAD_LO);

  // machine cycle strobe: one clock in twelve
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mcDiv_q <= 4'h0;
    end else begin
      mcDiv_q <= mcTick ? 4'h0 : mcDiv_q + 4'h1;
    end
  end

  // half-rate phase for the 2:1 prescaler, advanced once per machine cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prescPhase_q <= 1'b0;
    end else if (mcTick) begin
      prescPhase_q <= ~prescPhase_q;
    end
  end

  ccut_edge_sampler uCountPin (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .pinIn    (gpTimerExtCountGatePin),
    .sampleEn (mcTick),
    .level    (gateLevel),
    .fallSeen (countFall)
  );

  ccut_edge_sampler uTrigPin (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .pinIn    (reloadTriggerPin),
    .sampleEn (mcTick),
    .level    (),
    .fallSeen (trigFall) // RULE13
  );

  // increment decision per input selection
  always_comb begin
    gpInc = 1'b0;
    unique case (inSel)
      CCUT_IN_STOP:  gpInc = 1'b0; // RULE24
      CCUT_IN_TIMER: gpInc = mcTick && (!gpPrescale || prescPhase_q); // RULE1
      CCUT_IN_COUNT: gpInc = countFall; // RULE3
      CCUT_IN_GATED: gpInc = mcTick && gateLevel && (!gpPrescale || prescPhase_q); // RULE2
    endcase
  end

  assign gpRoll    = gpInc && (gpCnt_q == 16'hffff);
  // edge pulse arrives the cycle after the low sample, so reload lands then
  assign extReload = rldOn && rldExt && trigFall; // RULE11 RULE13

  // general timer count
  // byte writes lose to reloads; an increment landing with a write is dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gpCnt_q <= 16'h0000;
    end else if (extReload) begin
      gpCnt_q <= reloadCompare_q; // RULE11
    end else if (gpRoll && rldOn && !rldExt) begin
      gpCnt_q <= reloadCompare_q; // RULE10
    end else if (regWr && regAddr == `CCUT_ADDR_GP_CNT_LOW) begin
      gpCnt_q[7:0] <= regWdata;
    end else if (regWr && regAddr == `CCUT_ADDR_GP_CNT_HIGH) begin
      gpCnt_q[15:8] <= regWdata;
    end else if (gpInc) begin
      gpCnt_q <= gpCnt_q + 16'h0001;
    end
  end

  // overflow flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ovfFlag_q <= 1'b0;
    end else if (gpRoll) begin
      ovfFlag_q <= 1'b1; // RULE6
    end else if (regWr && regAddr == `CCUT_ADDR_IRQ_REQ) begin
      ovfFlag_q <= regWdata[`CCUT_IR_OVERFLOW]; // RULE7
    end
  end

  // ext-reload flag: the enable gates only the flag, the reload always happens
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      extFlag_q <= 1'b0;
    end else if (extReload && irqEn_q[`CCUT_IE_EXT_RLD_EN]) begin
      extFlag_q <= 1'b1; // RULE11
    end else if (regWr && regAddr == `CCUT_ADDR_IRQ_REQ) begin
      extFlag_q <= regWdata[`CCUT_IR_EXT_RELOAD];
    end
  end

  // control and enable registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gpCtrl_q <= `CCUT_GP_CTRL_RESET;
      irqEn_q  <= `CCUT_IRQ_RESET;
    end else if (regWr && regAddr == `CCUT_ADDR_GP_CTRL) begin
      gpCtrl_q <= regWdata;
    end else if (regWr && regAddr == `CCUT_ADDR_IRQ_EN1) begin
      irqEn_q <= regWdata;
    end
  end

  // reload/compare pair, one byte per write
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reloadCompare_q <= 16'h0000;
    end else if (regWr && regAddr == `CCUT_ADDR_RC_LOW) begin
      reloadCompare_q[7:0] <= regWdata;
    end else if (regWr && regAddr == `CCUT_ADDR_RC_HIGH) begin
      reloadCompare_q[15:8] <= regWdata;
    end
  end

  // fast reload pair; the low byte write also restarts the fast timer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ftReload_q <= 16'h0000;
    end else if (wrLowReload) begin
      ftReload_q[7:0] <= regWdata;
    end else if (regWr && regAddr == `CCUT_ADDR_FT_RELOAD_HI) begin
      ftReload_q[15:8] <= regWdata; // RULE21
    end
  end

  // fast timer control: writable at any time, overflow flag kept apart
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ftCtrl_q <= `CCUT_FT_CTRL_RESET; // RULE17
    end else if (regWr && regAddr == `CCUT_ADDR_FT_CTRL) begin
      ftCtrl_q <= regWdata; // RULE17
    end
  end

  // held in reset outside run, so the first tick after a load is a full period
  ccut_fast_prescaler uFastPresc (
    .clk_sys (clk_sys),
    .srst    (srst),
    .restart (ftState_q != CCUT_FT_RUN),
    .divSel  (ftCtrl_q[2:0]), // RULE16
    .tick    (ftTick)
  );

  // judged on the live count, so reload, flag and output low share one edge
  assign ftRoll = (ftState_q == CCUT_FT_RUN) && ftTick && (ftCnt_q == 16'hffff);

  // fast timer: idle until the low reload byte is written, then loads and runs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ftState_q <= CCUT_FT_IDLE;
      ftCnt_q   <= 16'h0000;
    end else begin
      unique case (ftState_q)
        CCUT_FT_IDLE: begin
          if (wrLowReload) begin
            ftState_q <= CCUT_FT_LOAD; // RULE19
          end
        end
        CCUT_FT_RUN: begin
          if (wrLowReload) begin
            ftState_q <= CCUT_FT_LOAD; // RULE20
          end else if (ftRoll) begin
            ftCnt_q <= ftReload_q; // RULE18
          end else if (ftTick) begin
            ftCnt_q <= ftCnt_q + 16'h0001;
          end
        end
        CCUT_FT_LOAD: begin
          ftCnt_q   <= ftReload_q; // RULE20
          // back-to-back low byte writes keep reloading
          ftState_q <= wrLowReload ? CCUT_FT_LOAD : CCUT_FT_RUN;
        end
        default: ftState_q <= CCUT_FT_IDLE;
      endcase
    end
  end

  // fast overflow flag; set wins over a clear by writing 0
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ftOvf_q <= 1'b0;
    end else if (ftRoll) begin
      ftOvf_q <= 1'b1; // RULE23
    end else if (regWr && regAddr == `CCUT_ADDR_FT_CTRL) begin
      ftOvf_q <= regWdata[`CCUT_FC_OVERFLOW];
    end
  end

  // compare mode 0 output for registers on the fast timer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fastCompareOut <= 1'b0;
    end else if (ftRoll) begin
      fastCompareOut <= 1'b0; // RULE15
    end else if (fastCompareMatch) begin
      fastCompareOut <= 1'b1; // RULE15
    end
  end

  // interrupt lines and compare mode, registered so every output is a flop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gpTimerIrq     <= 1'b0;
      fastTimerIrq   <= 1'b0;
      compareModeOne <= 1'b0;
    end else begin
      gpTimerIrq     <= irqEn_q[`CCUT_IE_GP_IRQ_EN] && (ovfFlag_q || extFlag_q); // RULE6 RULE12
      fastTimerIrq   <= irqEn_q[`CCUT_IE_FT_IRQ_EN] && ftOvf_q; // RULE22
      compareModeOne <= gpCtrl_q[`CCUT_GC_CMPMODE]; // RULE14
    end
  end

  // count copies lag the live counts by one cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gpTimerCount   <= 16'h0000;
      fastTimerCount <= 16'h0000;
    end else begin
      gpTimerCount   <= gpCnt_q;
      fastTimerCount <= ftCnt_q;
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `CCUT_ADDR_GP_CTRL:      regRdata <= gpCtrl_q;
        `CCUT_ADDR_IRQ_REQ:      regRdata <= {extFlag_q, ovfFlag_q, 6'h00};
        `CCUT_ADDR_IRQ_EN1:      regRdata <= irqEn_q;
        `CCUT_ADDR_RC_LOW:       regRdata <= reloadCompare_q[7:0];
        `CCUT_ADDR_RC_HIGH:      regRdata <= reloadCompare_q[15:8];
        `CCUT_ADDR_GP_CNT_LOW:   regRdata <= gpCnt_q[7:0];
        `CCUT_ADDR_GP_CNT_HIGH:  regRdata <= gpCnt_q[15:8];
        `CCUT_ADDR_FT_RELOAD_LO: regRdata <= ftReload_q[7:0];
        `CCUT_ADDR_FT_RELOAD_HI: regRdata <= ftReload_q[15:8];
        `CCUT_ADDR_FT_CTRL:      regRdata <= {ftCtrl_q[7:4], ftOvf_q, ftCtrl_q[2:0]};
        `CCUT_ADDR_FT_CNT_LOW:   regRdata <= ftCnt_q[7:0];
        `CCUT_ADDR_FT_CNT_HIGH:  regRdata <= ftCnt_q[15:8];
        default:                 regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule : ccut_timer_top

/* File: sim/ccut_timer_top_asserts.sv */
// port-level checks for the ccu time bases
`timescale 1ns/100ps
module ccut_timer_top_asserts (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  // compare line
  input wire logic        fastCompareMatch,
  input wire logic        fastCompareOut,
  // status
  input wire logic        gpTimerIrq,
  input wire logic        fastTimerIrq,
  input wire logic        compareModeOne,
  input wire logic [15:0] gpTimerCount,
  input wire logic [15:0] fastTimerCount
);
  logic [7:0]  gpCtrl_q;
  logic [15:0] rcVal_q;
  logic [15:0] ftRel_q;
  logic        gpIe_q;
  logic        ftIe_q;
  logic        ftOn_q;
  logic        gpPsExt_q;
  logic [4:0]  quiet_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // shadow of the registers that steer the counts, plus the interrupt enables
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gpCtrl_q <= 8'h00;
      rcVal_q  <= 16'h0000;
      ftRel_q  <= 16'h0000;
      gpIe_q   <= 1'b0;
      ftIe_q   <= 1'b0;
      ftOn_q   <= 1'b0;
      gpPsExt_q <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        8'hc8: gpCtrl_q <= regWdata;
        8'hb8: begin
          gpIe_q <= regWdata[1];
          ftIe_q <= regWdata[0];
        end
        8'hca: rcVal_q[7:0] <= regWdata;
        8'hcb: rcVal_q[15:8] <= regWdata;
        8'hdf: ftRel_q[15:8] <= regWdata;
        8'he1: gpPsExt_q <= regWdata[7];
        8'hde: begin
          ftRel_q[7:0] <= regWdata;
          ftOn_q       <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // cycles since any write; a fresh write may legally bend the count
  always_ff @(posedge clk_sys) begin
    if (srst || regWr) quiet_q <= 5'd0;
    else if (quiet_q != 5'd31) quiet_q <= quiet_q + 5'd1;
  end

  AST_CMODE: assert property (
    regWr && regAddr == 8'hc8 ##1 !(regWr && regAddr == 8'hc8) |=> compareModeOne == gpCtrl_q[2])
    else $error("compare mode copy wrong");
  AST_STOP: assert property (
    quiet_q == 5'd31 && gpCtrl_q[1:0] == 2'b00 && gpCtrl_q[4:3] != 2'b11 |-> $stable(gpTimerCount))
    else $error("count moved while stopped");
  AST_STEP: assert property (
    quiet_q == 5'd31 && !gpCtrl_q[4] && $changed(gpTimerCount) |-> gpTimerCount == $past(gpTimerCount) + 16'h1)
    else $error("count step not one");
  AST_RATE: assert property (
    quiet_q == 5'd31 && gpCtrl_q == 8'h01 && !gpPsExt_q && $changed(gpTimerCount) |->
    ##12 ($changed(gpTimerCount) || quiet_q != 5'd31)) else $error("timer period not 12");
  AST_RATE2: assert property (
    quiet_q == 5'd31 && (gpCtrl_q == 8'h81 || gpCtrl_q == 8'h01 && gpPsExt_q) && $changed(gpTimerCount) |->
    ##24 ($changed(gpTimerCount) || quiet_q != 5'd31)) else $error("prescaled period not 24");
  AST_GPRLD: assert property (
    gpCtrl_q[4:3] == 2'b10 && $past(gpTimerCount) == 16'hffff && gpTimerCount != 16'hffff
    |-> gpTimerCount == rcVal_q) else $error("overflow reload wrong");
  AST_GPIRQ: assert property (
    gpTimerIrq |-> $past(gpIe_q)) else $error("timer irq while disabled");
  AST_FTIRQ: assert property (
    fastTimerIrq |-> $past(ftIe_q)) else $error("fast irq while disabled");
  AST_FTIDLE: assert property (
    !ftOn_q |-> fastTimerCount == 16'h0000) else $error("fast timer ran before start");
  AST_FTSTART: assert property (
    regWr && regAddr == 8'hde |-> ##[1:4] fastTimerCount == ftRel_q) else $error("fast restart not loaded");
  AST_FTWRAP: assert property (
    $past(fastTimerCount) == 16'hffff && fastTimerCount != 16'hffff |-> fastTimerCount == ftRel_q)
    else $error("fast wrap not reloaded");
  AST_CMPHI: assert property (
    $rose(fastCompareOut) |-> $past(fastCompareMatch) || $past(fastCompareMatch, 2))
    else $error("compare line rose without match");
endmodule : ccut_timer_top_asserts

bind ccut_timer_top ccut_timer_top_asserts chk_u (.*);

/* File: sim/ccut_pin_model.sv */
// pin-side model: count or gate source and reload trigger
`timescale 1ns/100ps
module ccut_pin_model (
  // clock
  input  wire logic clk_sys,
  // pins, idle high as with port pull-ups
  output logic      cntPin,
  output logic      trigPin
);
  initial begin
    cntPin  = 1'b1;
    trigPin = 1'b1;
  end
  // every level stays at least a machine cycle so one sample sees it
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge clk_sys);
      cntPin <= 1'b0;
      repeat (hold) @(posedge clk_sys);
      cntPin <= 1'b1;
    end
  endtask : pulses
  task automatic level(input logic v);
    @(posedge clk_sys);
    cntPin <= v;
  endtask : level
  task automatic trig();
    repeat (13) @(posedge clk_sys);
    trigPin <= 1'b0;
    repeat (13) @(posedge clk_sys);
    trigPin <= 1'b1;
  endtask : trig
endmodule : ccut_pin_model

/* File: sim/tb_ccut_timer_top.sv */
// self-checking bench for the ccu time bases
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_ccut_timer_top;
  logic        clk_sys, srst, regWr, regRd, fastCompareMatch, cntPin, trigPin;
  logic        fastCompareOut, gpTimerIrq, fastTimerIrq, compareModeOne;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [15:0] gpTimerCount, fastTimerCount, snap;
  int          err_total = 0;
  int          check_count = 0;

  ccut_timer_top dut_u (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gpTimerExtCountGatePin(cntPin),
    .reloadTriggerPin(trigPin), .fastCompareMatch(fastCompareMatch), .fastCompareOut(fastCompareOut),
    .gpTimerIrq(gpTimerIrq), .fastTimerIrq(fastTimerIrq), .compareModeOne(compareModeOne),
    .gpTimerCount(gpTimerCount), .fastTimerCount(fastTimerCount));
  ccut_pin_model pin_u (.clk_sys(clk_sys), .cntPin(cntPin), .trigPin(trigPin));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1;
    `CHK("read data", e, regRdata)
  endtask : rd
  // settle past the edge so flops have landed before looking
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic complete_run();
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    fastCompareMatch = 1'b0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rd(8'he1, 8'h00);
    rd(8'hc8, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'he1, 8'h05);
    rd(8'he1, 8'h05);
    wr(8'hc8, 8'h04);
    wt(3);
    `CHK("compare mode", 1'b1, compareModeOne)
    `CHK("fast idle", 16'h0000, fastTimerCount)
    for (int p = 0; p < 3; p++) begin
      wr(8'he1, {p[1], 7'h00});
      wr(8'hc8, {p[0], 7'h01});
      wt(1);
      snap = gpTimerCount;
      wt(240);
      `CHK("timer rate", 1'b1, int'(gpTimerCount - snap) inside {[(p == 0 ? 19 : 9) : (p == 0 ? 21 : 11)]})
    end
    wr(8'he1, 8'h00);
    wr(8'hc8, 8'h00);
    wt(30);
    snap = gpTimerCount;
    wt(100);
    `CHK("stopped", snap, gpTimerCount)
    // overflow, first without reload, then with reload from the reload/compare pair
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hb8, 8'h02);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h01);
    wt(40);
    `CHK("ovf no reload", 1'b1, gpTimerCount inside {[16'h0000 : 16'h0002]})
    rd(8'hc0, 8'h40);
    wr(8'hc0, 8'h00);
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h11);
    wt(40);
    `CHK("ovf reload", 1'b1, gpTimerCount inside {[16'h1234 : 16'h1236]})
    `CHK("ovf irq", 1'b1, gpTimerIrq)
    rd(8'hc0, 8'h40);
    wr(8'hc0, 8'h00);
    rd(8'hc0, 8'h00);
    // gated timer
    wr(8'hc8, 8'h03);
    pin_u.level(1'b1);
    wt(30);
    snap = gpTimerCount;
    wt(120);
    `CHK("gate open", 1'b1, int'(gpTimerCount - snap) inside {[9 : 11]})
    pin_u.level(1'b0);
    wt(30);
    snap = gpTimerCount;
    wt(120);
    `CHK("gate shut", snap, gpTimerCount)
    // event counting, prompt and slow source
    pin_u.level(1'b1);
    wr(8'hc8, 8'h02);
    wt(30);
    snap = gpTimerCount;
    pin_u.pulses(5, 13);
    pin_u.pulses(2, 30);
    wt(40);
    `CHK("events", snap + 16'd7, gpTimerCount)
    // reload on trigger edge, flag only with its enable
    wr(8'hc8, 8'h18);
    wr(8'hb8, 8'h82);
    wr(8'hcc, 8'h00);
    pin_u.trig();
    wt(40);
    `CHK("trig reload", 16'h1234, gpTimerCount)
    `CHK("ext irq", 1'b1, gpTimerIrq)
    rd(8'hc0, 8'h80);
    wr(8'hc0, 8'h00);
    wr(8'hb8, 8'h02);
    wr(8'hcc, 8'h00);
    pin_u.trig();
    wt(40);
    `CHK("trig reload", 16'h1234, gpTimerCount)
    rd(8'hc0, 8'h00);
    // fast timer: every divider setting, restart per setting
    wr(8'hdf, 8'h00);
    for (int d = 0; d < 8; d++) begin
      wr(8'he1, d[7:0]);
      wr(8'hde, 8'h00);
      wt(4);
      snap = fastTimerCount;
      wt(8 << (d + 1));
      `CHK("fast div", 1'b1, int'(fastTimerCount - snap) inside {[7 : 9]})
    end
    wr(8'hb8, 8'h01);
    wr(8'he1, 8'h00);
    wr(8'hdf, 8'hff);
    wr(8'hde, 8'hf0);
    @(posedge clk_sys);
    fastCompareMatch <= 1'b1;
    @(posedge clk_sys);
    fastCompareMatch <= 1'b0;
    wt(3);
    `CHK("match high", 1'b1, fastCompareOut)
    wt(40);
    `CHK("wrap low", 1'b0, fastCompareOut)
    `CHK("fast irq", 1'b1, fastTimerIrq)
    rd(8'he1, 8'h08);
    `CHK("fast reloaded", 1'b1, fastTimerCount >= 16'hfff0)
    complete_run();
  end
endmodule : tb_ccut_timer_top
